// ===== rtl/mid_range_opcode_decoder.sv
// Opcode decoder and executor with AXI4-Lite control
//
// Behaviour
// RULE1: Literal and accumulator relative branches, two cycles
// RULE2: Call, jump, accumulator call; two cycles
// RULE3: Literal, interrupt and subroutine returns; two cycles
// RULE4: Standby and watchdog clear update status flags
// RULE5: Accumulator copied to options register, flags kept
// RULE6: Direction load to port A/B/C for 5-7
// RULE7: Add six-bit literal to selected pointer
// RULE8: Indirect load with modifier, sets zero
// RULE9: Indexed indirect load, sets zero
// RULE10: Indirect store with modifier, flags kept
// RULE11: Indexed indirect store, flags kept
// RULE12: Program counter change costs second idle cycle
// RULE13: Pointer top bit set adds one cycle
// RULE14: Nibble swap to accumulator or file
// RULE15: Literal XOR into accumulator, sets zero
// RULE16: File XOR to chosen destination, sets zero
// RULE17: Modifier encoding from parameter table
// RULE18: No-op and software reset single cycle
//
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module mid_range_opcode_decoder
  import opdec_pkg::*;
#(
  parameter logic [7:0] MM_MAP = MM_TABLE
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Data memory
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_we,
  input wire logic [7:0] mem_rdata,
  // Core side effects
  output logic [10:0] program_counter,
  output logic [7:0] port_a_direction,
  output logic [7:0] port_b_direction,
  output logic [7:0] port_c_direction,
  output logic [7:0] option_q,
  output logic timeout_flag,
  output logic power_down_flag,
  output logic zero_flag,
  output logic reset_req
);
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_EXEC = 4'b0010,
    S_WAIT = 4'b0100,
    S_DONE = 4'b1000
  } state_t;

  state_t state_q;
  logic [13:0] op_q;
  logic [7:0] acc_q;
  logic [7:0] ptr_q [2];
  logic [1:0] wait_q;
  logic ws_q;
  logic [3:0] awa_q;
  logic [31:0] wd_q;
  logic [15:0] cls;

  opdec_core u_core (
    .op(op_q),
    .cls(cls)
  );

  function automatic logic [7:0] swap_nib(input logic [7:0] v);
    swap_nib = {v[3:0], v[7:4]};
  endfunction : swap_nib

  // Operand fields
  wire sel_n = cls[14] ? op_q[2] : op_q[6]; // RULE8
  wire [1:0] mm_field = op_q[1:0];
  wire [1:0] mm_code = MM_MAP[2*mm_field +: 2];
  wire mm_dec = mm_code[0];
  wire mm_post = mm_code[1];
  wire [7:0] ptr_sel = ptr_q[sel_n];
  wire [7:0] ptr_step = mm_dec ? ptr_sel - 8'h01 : ptr_sel + 8'h01;
  wire [7:0] lit6 = {{2{op_q[5]}}, op_q[5:0]};
  wire imov = cls[14];
  wire idx = cls[15];
  wire imov_load = imov && !op_q[3];
  wire idx_load = idx && !op_q[7];
  // RULE17
  wire [7:0] imov_addr = mm_post ? ptr_sel : ptr_step;
  wire [7:0] idx_addr = ptr_sel + lit6;
  wire is_swap = (op_q & M_FILE) == V_SWAP;
  wire is_xorf = (op_q & M_FILE) == V_XORF;
  wire is_xorl = (op_q & M_FILE) == V_XORL;
  wire file_op = is_swap || is_xorf;
  wire dest_file = op_q[7];
  wire [7:0] file_addr = {1'b0, op_q[6:0]};
  // RULE12
  wire pc_change = |cls[7:0];
  // RULE13
  wire extra = (imov || idx) && ptr_sel[7];
  wire [1:0] wait_cnt = {1'b0, pc_change} + {1'b0, extra};
  wire [7:0] swap_res = swap_nib(mem_rdata);
  wire [7:0] xorf_res = acc_q ^ mem_rdata;
  wire [7:0] xorl_res = acc_q ^ op_q[7:0];
  wire [10:0] bra_off = {{2{op_q[8]}}, op_q[8:0]};
  wire [10:0] pc_next = cls[0] ? program_counter + bra_off + 11'h001 :
                        cls[1] ? program_counter + {3'h0, acc_q} + 11'h001 :
                        cls[3] ? {3'h0, acc_q} :
                        (cls[2] || cls[4]) ? op_q[10:0] :
                        program_counter + 11'h001;
  // Bus decode
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire busy = state_q != S_IDLE;
  wire wr_ok = awa_q == A_OPCODE || awa_q == A_CTRL || awa_q == A_ACCUM;
  wire rd_hit = s_axi_araddr == A_STAT || s_axi_araddr == A_CTRL ||
                s_axi_araddr == A_ACCUM || s_axi_araddr == A_PTR0;
  wire [31:0] rd_val = s_axi_araddr == A_STAT ? {16'h0, zero_flag, power_down_flag,
                         timeout_flag, busy, 12'h0} :
                       s_axi_araddr == A_ACCUM ? {24'h0, acc_q} :
                       s_axi_araddr == A_PTR0 ? {16'h0, ptr_q[1], ptr_q[0]} :
                       {18'h0, op_q};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_arready <= 1'b1;
      awa_q <= 4'h0;
      wd_q <= 32'h0;
      ws_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OK;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OK;
      s_axi_rdata <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_ok && !busy) ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
        s_axi_rdata <= rd_hit ? rd_val : 32'h0;
        s_axi_rresp <= rd_hit ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
  wire wr_now = wr_go && wr_ok && !busy && ws_q;
  wire go = wr_now && awa_q == A_CTRL && wd_q[CTRL_GO];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= S_IDLE;
      op_q <= OP_NOOP;
      acc_q <= 8'h00;
      ptr_q[0] <= 8'h00;
      ptr_q[1] <= 8'h00;
      wait_q <= 2'h0;
      program_counter <= 11'h000;
      port_a_direction <= 8'hff;
      port_b_direction <= 8'hff;
      port_c_direction <= 8'hff;
      option_q <= 8'hff;
      timeout_flag <= 1'b1;
      power_down_flag <= 1'b1;
      zero_flag <= 1'b0;
      reset_req <= 1'b0;
      mem_addr <= 8'h00;
      mem_wdata <= 8'h00;
      mem_we <= 1'b0;
    end else begin
      mem_we <= 1'b0;
      reset_req <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (wr_now && awa_q == A_OPCODE) op_q <= wd_q[13:0];
          if (wr_now && awa_q == A_ACCUM) acc_q <= wd_q[7:0];
          if (go) state_q <= S_EXEC;
        end
        S_EXEC: begin
          program_counter <= pc_next; // RULE1 RULE2
          wait_q <= wait_cnt;
          state_q <= (wait_cnt != 2'h0) ? S_WAIT : S_DONE; // RULE12 RULE13
          if (cls[6]) acc_q <= op_q[7:0]; // RULE3
          if (cls[8]) begin
            timeout_flag <= 1'b1; // RULE4
            power_down_flag <= 1'b1;
          end
          if (cls[11]) begin
            timeout_flag <= 1'b1; // RULE4
            power_down_flag <= 1'b0;
          end
          if (cls[9]) option_q <= acc_q; // RULE5
          if (cls[12]) begin
            case (op_q[2:0])
              DIR_A: port_a_direction <= acc_q; // RULE6
              DIR_B: port_b_direction <= acc_q;
              default: port_c_direction <= acc_q;
            endcase
          end
          if (cls[13]) ptr_q[sel_n] <= ptr_sel + lit6; // RULE7
          if (imov) begin
            mem_addr <= imov_addr; // RULE8 RULE10
            ptr_q[sel_n] <= ptr_step;
            mem_we <= !imov_load;
            mem_wdata <= acc_q;
          end
          if (idx) begin
            mem_addr <= idx_addr; // RULE9 RULE11
            mem_we <= !idx_load;
            mem_wdata <= acc_q;
          end
          if (file_op) mem_addr <= file_addr;
          if (is_xorl) begin
            acc_q <= xorl_res; // RULE15
            zero_flag <= xorl_res == 8'h00;
          end
          if (cls[10]) reset_req <= 1'b1; // RULE18
        end
        S_WAIT: begin
          if (wait_q <= 2'h1) state_q <= S_DONE;
          wait_q <= wait_q - 2'h1;
        end
        S_DONE: begin
          // Memory read data valid one cycle after address
          if (imov_load || idx_load) begin
            acc_q <= mem_rdata; // RULE8 RULE9
            zero_flag <= mem_rdata == 8'h00;
          end
          if (is_swap) begin
            if (dest_file) begin
              mem_we <= 1'b1; // RULE14
              mem_wdata <= swap_res;
            end else acc_q <= swap_res;
          end
          if (is_xorf) begin
            zero_flag <= xorf_res == 8'h00; // RULE16
            if (dest_file) begin
              mem_we <= 1'b1;
              mem_wdata <= xorf_res;
            end else acc_q <= xorf_res;
          end
          state_q <= S_IDLE;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Checks
  property p_branch_two;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && (cls[0] || cls[1]) && !extra) |=> state_q == S_WAIT ##1
      state_q == S_DONE;
  endproperty
  a_branch_two: assert property (p_branch_two) else $error("branch not two cycles"); // RULE1
  property p_jump;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && cls[4]) |=> program_counter == $past(op_q[10:0]);
  endproperty
  a_jump: assert property (p_jump) else $error("jump target wrong"); // RULE2
  property p_retlit;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && cls[6]) |=> acc_q == $past(op_q[7:0]);
  endproperty
  a_retlit: assert property (p_retlit) else $error("literal return wrong"); // RULE3
  property p_standby;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && cls[11]) |=> !power_down_flag && timeout_flag;
  endproperty
  a_standby: assert property (p_standby) else $error("standby flags wrong"); // RULE4
  property p_opt;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && cls[9]) |=> option_q == $past(acc_q) && $stable(zero_flag);
  endproperty
  a_opt: assert property (p_opt) else $error("option load wrong"); // RULE5
  property p_dir;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && cls[12] && op_q[2:0] == DIR_B) |=>
      port_b_direction == $past(acc_q);
  endproperty
  a_dir: assert property (p_dir) else $error("direction load wrong"); // RULE6
  property p_single;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && !pc_change && !extra) |=> state_q == S_DONE;
  endproperty
  a_single: assert property (p_single) else $error("single cycle op stalled"); // RULE12
  property p_extra;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && idx && ptr_sel[7]) |=> state_q == S_WAIT ##1 state_q == S_DONE;
  endproperty
  a_extra: assert property (p_extra) else $error("missing extra cycle"); // RULE13
  property p_xorl;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && is_xorl) |=> acc_q == ($past(acc_q) ^ $past(op_q[7:0]));
  endproperty
  a_xorl: assert property (p_xorl) else $error("literal xor wrong"); // RULE15
  property p_reset;
    @(posedge aclk) disable iff (!aresetn)
      (state_q == S_EXEC && cls[10]) |=> reset_req ##1 !reset_req;
  endproperty
  a_reset: assert property (p_reset) else $error("reset request wrong"); // RULE18
  c_call: cover property (@(posedge aclk) state_q == S_EXEC && cls[2]);
  c_imov: cover property (@(posedge aclk) state_q == S_EXEC && imov);
  c_swap: cover property (@(posedge aclk) state_q == S_DONE && is_swap && dest_file);
endmodule : mid_range_opcode_decoder

// ===== rtl/opdec_pkg.sv
// Package: opcode patterns, register offsets and constants for the decoder
package opdec_pkg;
  localparam logic [13:0] OP_NOOP = 14'h0000;
  localparam logic [13:0] OP_SWRESET = 14'h0001;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_RETINT = 14'h0009;
  localparam logic [13:0] OP_CALLACC = 14'h000a;
  localparam logic [13:0] OP_BRACC = 14'h000b;
  localparam logic [13:0] OP_OPTLD = 14'h0062;
  localparam logic [13:0] OP_STANDBY = 14'h0063;
  localparam logic [13:0] OP_WDTCLR = 14'h0064;
  // Masked families: value and mask
  localparam logic [13:0] M_BREL = 14'h3e00;
  localparam logic [13:0] V_BREL = 14'h3200;
  localparam logic [13:0] M_CALL = 14'h3800;
  localparam logic [13:0] V_CALL = 14'h2000;
  localparam logic [13:0] V_JUMP = 14'h2800;
  localparam logic [13:0] M_RETLIT = 14'h3f00;
  localparam logic [13:0] V_RETLIT = 14'h3400;
  localparam logic [13:0] M_PADD = 14'h3f80;
  localparam logic [13:0] V_PADD = 14'h3100;
  localparam logic [13:0] M_IMOV = 14'h3ff0;
  localparam logic [13:0] V_IMOV = 14'h0010;
  localparam logic [13:0] M_IDX = 14'h3f00;
  localparam logic [13:0] V_IDX = 14'h3f00;
  localparam logic [13:0] M_DIR = 14'h3ff8;
  localparam logic [13:0] V_DIR = 14'h0060;
  localparam logic [13:0] M_FILE = 14'h3f00;
  localparam logic [13:0] V_SWAP = 14'h0e00;
  localparam logic [13:0] V_XORF = 14'h0600;
  localparam logic [13:0] V_XORL = 14'h3a00;
  localparam logic [2:0] DIR_A = 3'h5;
  localparam logic [2:0] DIR_B = 3'h6;
  localparam logic [2:0] DIR_C = 3'h7;
  // Register map (byte addresses)
  localparam logic [3:0] A_OPCODE = 4'h0;
  localparam logic [3:0] A_CTRL = 4'h4;
  localparam logic [3:0] A_ACCUM = 4'h8;
  localparam logic [3:0] A_PTR0 = 4'hc;
  localparam logic [3:0] A_STAT = 4'h0;
  localparam int CTRL_GO = 0;
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Default pre/post modifier table: inc-pre, dec-pre, inc-post, dec-post
  localparam logic [7:0] MM_TABLE = 8'he4;
endpackage : opdec_pkg

// ===== rtl/opdec_core.sv
// Combinational classifier of one 14-bit opcode
`timescale 1ns/1ps
module opdec_core
  import opdec_pkg::*;
(
  // Opcode in
  input wire logic [13:0] op,
  // Class out
  output logic [15:0] cls
);
  function automatic logic hit(input logic [13:0] o, input logic [13:0] m,
                               input logic [13:0] v);
    hit = (o & m) == v;
  endfunction : hit
  // 0 rel branch,1 acc branch,2 call,3 acc call,4 jump,5 retint,6 retlit,7 ret,8 wdt,9 opt,
  // 10 swreset,11 standby,12 dir,13 padd,14 imov,15 idx
  assign cls[0] = hit(op, M_BREL, V_BREL);
  assign cls[1] = op == OP_BRACC;
  assign cls[2] = hit(op, M_CALL, V_CALL);
  assign cls[3] = op == OP_CALLACC;
  assign cls[4] = hit(op, M_CALL, V_JUMP);
  assign cls[5] = op == OP_RETINT;
  assign cls[6] = hit(op, M_RETLIT, V_RETLIT);
  assign cls[7] = op == OP_RETURN;
  assign cls[8] = op == OP_WDTCLR;
  assign cls[9] = op == OP_OPTLD;
  assign cls[10] = op == OP_SWRESET;
  assign cls[11] = op == OP_STANDBY;
  assign cls[12] = hit(op, M_DIR, V_DIR) && op[2:0] >= DIR_A;
  assign cls[13] = hit(op, M_PADD, V_PADD);
  assign cls[14] = hit(op, M_IMOV, V_IMOV);
  assign cls[15] = hit(op, M_IDX, V_IDX);
endmodule : opdec_core

// ===== tb/data_mem.sv
// Data memory model facing the decoder's memory port
`timescale 1ns/1ps
module data_mem (
  // Clock
  input wire logic aclk,
  // Memory port
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic mem_we,
  output logic [7:0] mem_rdata
);
  logic [7:0] cells [256];
  // Registered address answered within the same cycle
  assign mem_rdata = cells[mem_addr];
  always @(posedge aclk) begin
    if (mem_we) begin
      cells[mem_addr] <= mem_wdata;
    end
  end
endmodule : data_mem

// ===== tb/mid_range_opcode_decoder_test.sv
// Self-checking bench for the opcode decoder
`timescale 1ns/1ps
module mid_range_opcode_decoder_test;
  import opdec_pkg::*;
  logic aclk, aresetn;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] mem_addr, mem_wdata, mem_rdata, option_q;
  logic [7:0] port_a_direction, port_b_direction, port_c_direction;
  logic mem_we, timeout_flag, power_down_flag, zero_flag, reset_req;
  logic [10:0] program_counter;
  int mismatches = 0;
  int n_tests = 0;
  int n_rst = 0;

  mid_range_opcode_decoder dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .mem_addr, .mem_wdata, .mem_we, .mem_rdata, .program_counter, .port_a_direction,
    .port_b_direction, .port_c_direction, .option_q, .timeout_flag, .power_down_flag,
    .zero_flag, .reset_req);
  data_mem mem_u (.aclk, .mem_addr, .mem_wdata, .mem_we, .mem_rdata);

  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    if (reset_req === 1'b1) n_rst <= n_rst + 1;
  end

  task automatic end_of_test();
    if (mismatches == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] st,
                    output logic [1:0] r);
    logic ah, wh, bh;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ah = s_axi_awvalid && s_axi_awready;
      wh = s_axi_wvalid && s_axi_wready;
      bh = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
      if (bh) begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    mismatches++;
    end_of_test();
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ah, rh;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(negedge aclk);
      ah = s_axi_arvalid && s_axi_arready;
      rh = s_axi_rvalid;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ah) s_axi_arvalid <= 1'b0;
      if (rh) begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    mismatches++;
    end_of_test();
  endtask : rd

  // Load opcode, start it, poll busy until clear
  task automatic exec(input logic [13:0] op);
    logic [1:0] r;
    logic [31:0] s;
    wr(A_OPCODE, {18'h0, op}, 4'hf, r);
    wr(A_CTRL, 32'h1, 4'hf, r);
    for (int i = 0; i < 20; i++) begin
      rd(A_STAT, s);
      if (s[12] === 1'b0) return;
    end
    mismatches++;
    end_of_test();
  endtask : exec

  task automatic t_reset();
    chk({8'h0, port_a_direction, port_b_direction, port_c_direction}, 32'hffffff);
    chk({24'h0, option_q}, 32'hff);
    chk({29'h0, timeout_flag, power_down_flag, zero_flag}, 32'h6);
  endtask : t_reset

  task automatic t_flow();
    exec(V_JUMP | 14'h100);
    chk({21'h0, program_counter}, 32'h100);
    exec(V_BREL | 14'h005);
    chk({21'h0, program_counter}, 32'h106);
    exec(V_BREL | 14'h1fe);
    chk({21'h0, program_counter}, 32'h105);
    exec(V_CALL | 14'h050);
    chk({21'h0, program_counter}, 32'h50);
    exec(OP_RETURN);
    chk({21'h0, program_counter}, 32'h51);
    exec(OP_NOOP);
    chk({21'h0, program_counter}, 32'h52);
  endtask : t_flow

  task automatic t_acc();
    logic [31:0] v;
    logic [1:0] r;
    wr(A_ACCUM, 32'h5a, 4'hf, r);
    wr(A_ACCUM, 32'h11, 4'he, r);
    rd(A_ACCUM, v);
    chk(v & 32'hff, 32'h5a);
    exec(V_XORL | 14'h05a);
    rd(A_ACCUM, v);
    chk({v[7:0], 7'h0, zero_flag}, 32'h1);
    exec(V_RETLIT | 14'h081);
    rd(A_ACCUM, v);
    chk(v & 32'hff, 32'h81);
    exec(OP_OPTLD);
    chk({23'h0, option_q, zero_flag}, 32'h103);
    exec(V_XORL | 14'h0ff);
    rd(A_ACCUM, v);
    chk({v[7:0], 7'h0, zero_flag}, 32'h7e00);
  endtask : t_acc

  task automatic t_inherent();
    logic [1:0] r;
    for (int f = 5; f < 8; f++) begin
      wr(A_ACCUM, 32'h10 + f, 4'hf, r);
      exec(V_DIR | 14'(f));
    end
    chk({8'h0, port_a_direction, port_b_direction, port_c_direction}, 32'h151617);
    exec(OP_STANDBY);
    chk({30'h0, timeout_flag, power_down_flag}, 32'h2);
    exec(OP_WDTCLR);
    chk({30'h0, timeout_flag, power_down_flag}, 32'h3);
    exec(OP_SWRESET);
    chk(n_rst, 32'h1);
  endtask : t_inherent

  task automatic t_indirect();
    logic [31:0] p;
    logic [7:0] b;
    logic [1:0] r;
    rd(A_PTR0, p);
    b = p[7:0] + 8'h10;
    exec(V_PADD | 14'h010);
    rd(A_PTR0, p);
    chk(p & 32'hff, {24'h0, b});
    wr(A_ACCUM, 32'h3c, 4'hf, r);
    exec(V_IDX | 14'h083);
    chk({24'h0, mem_u.cells[b + 8'h3]}, 32'h3c);
    mem_u.cells[b] = 8'h77;
    exec(V_IMOV | 14'h002);
    rd(A_ACCUM, p);
    chk({p[7:0], 7'h0, zero_flag}, 32'h7700);
    rd(A_PTR0, p);
    chk(p & 32'hff, {24'h0, b + 8'h1});
    mem_u.cells[b] = 8'h00;
    exec(V_IMOV | 14'h009);
    chk({24'h0, mem_u.cells[b]}, 32'h77);
    mem_u.cells[b + 8'h1] = 8'h00;
    exec(V_IDX | 14'h001);
    rd(A_ACCUM, p);
    chk({p[7:0], 7'h0, zero_flag}, 32'h1);
    mem_u.cells[8'h01] = 8'ha5;
    exec(V_IMOV | 14'h004);
    rd(A_PTR0, p);
    chk(p & 32'hffff, 32'h0110);
    exec(V_PADD | 14'h07e);
    rd(A_PTR0, p);
    chk(p & 32'hffff, 32'hff10);
    exec(V_IDX | 14'h0c1);
    chk({24'h0, mem_u.cells[8'h00]}, 32'ha5);
  endtask : t_indirect

  task automatic t_file();
    logic [31:0] v;
    mem_u.cells[8'h20] = 8'h3c;
    exec(V_SWAP | 14'h020);
    rd(A_ACCUM, v);
    chk(v & 32'hff, 32'hc3);
    exec(V_SWAP | 14'h0a0);
    chk({24'h0, mem_u.cells[8'h20]}, 32'hc3);
    mem_u.cells[8'h21] = 8'hc3;
    exec(V_XORF | 14'h0a1);
    chk({mem_u.cells[8'h21], 7'h0, zero_flag}, 32'h1);
    mem_u.cells[8'h22] = 8'h0f;
    exec(V_XORF | 14'h022);
    rd(A_ACCUM, v);
    chk({v[7:0], 7'h0, zero_flag}, 32'hcc00);
  endtask : t_file

  task automatic t_refuse();
    logic [1:0] r;
    logic [31:0] v;
    wr(A_PTR0, 32'h0, 4'hf, r);
    chk({30'h0, r}, {30'h0, RESP_ERR});
    rd(4'h2, v);
    chk(v, 32'h0);
    chk({30'h0, s_axi_rresp}, {30'h0, RESP_ERR});
  endtask : t_refuse

  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_flow();
    t_acc();
    t_inherent();
    t_indirect();
    t_file();
    t_refuse();
    end_of_test();
  end
endmodule : mid_range_opcode_decoder_test
